// File: logic/supervisor_pkg.sv
// Functional notes
// - Reset event pulls output low after filter, holds it, then releases after selected delay.
// - At power-up output stays low until supply is good, then first delay.
// - Undervoltage threshold code is writable; default falling threshold after power-on.
// - Mode code 11 in valid mode write performs soft reset to Init, defaults.
// - Soft reset request ignored outside Normal and Stop modes.
// - Pin option 0 lets soft reset pulse output with delay; 1 leaves it.
// - Watchdog type select: time-out by default, or window operation.
// - Watchdog type and period change only in Normal; Stop keeps them (a soft reset in Stop restores their defaults).
// - Long open window after Init release; off in Sleep/Restart; restarts on Normal.
// - Writing new watchdog timing restarts the timer with the new setting.
// - Host triggers by a valid control write, taken when the write is decoded.
// - Eight periods 10 ms to 10 s, shared by both watchdog types.
// - Failure sets flags, asserts reset, enters Restart/Fail-Safe; release gives Normal.
// - Software development mode: missed trigger only restarts long open window.
// - Flags clear on good trigger and when watchdog is off in Stop/Sleep.
// - Time-out type accepts trigger any time; each trigger starts fresh period.
// - Time-out expiry asserts reset and enters Restart or Fail-Safe.
// - Window type: trigger starts closed then open window; only open accepts.
// - Closed window is 60 percent of period; period is open window middle.
// - Trigger in closed window or expiry causes watchdog reset.
// - Control write with odd parity ignored and sets serial failure flag.
package supervisor_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_NS       = 10_000;
  localparam int unsigned TICK_US       = TICK_NS / 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TDIV_W        = 9;

  localparam int unsigned RF_US      = 10;
  localparam int unsigned RD1_US     = 10_000;
  localparam int unsigned RD2_US     = 2_000;
  localparam int unsigned LW_MS      = 200;
  localparam int unsigned RF_TICKS   = (RF_US + TICK_US - 1) / TICK_US;
  localparam int unsigned RD1_TICKS  = (RD1_US + TICK_US - 1) / TICK_US;
  localparam int unsigned RD2_TICKS  = (RD2_US + TICK_US - 1) / TICK_US;
  localparam int unsigned LW_TICKS   = LW_MS * 1000 / TICK_US;
  localparam int unsigned MS_TICKS   = 1000 / TICK_US;

  localparam int unsigned PERIOD_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};
  localparam int unsigned CLOSED_PCT   = 60;
  localparam int unsigned OPEN_END_PCT = 140;

  localparam int unsigned RCNT_W = 11;
  localparam int unsigned WCNT_W = 21;

  localparam int unsigned WDC_PERIOD_LSB = 0;
  localparam int unsigned WDC_TYPE_BIT   = 3;

  localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CMD_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_CMD_STOP   = 2'h2;
  localparam logic [1:0] MODE_CMD_SOFT   = 2'h3;

  localparam logic       TYPE_RST   = 1'h0;
  localparam logic [2:0] PERIOD_RST = 3'h2;
  localparam logic [1:0] THR_RST    = 2'h0;
  localparam logic       DSEL_RST   = 1'h0;
  localparam logic       PINOPT_RST = 1'h0;
  localparam logic       FSSEL_RST  = 1'h0;
  localparam logic [1:0] FLAGS_MAX  = 2'h3;

  typedef enum logic [2:0] {DM_INIT, DM_NORMAL, DM_STOP, DM_SLEEP, DM_RESTART,
                            DM_FAILSAFE} dev_mode_type;
  typedef enum logic [1:0] {RS_HIGH, RS_FILT, RS_LOW, RS_DELAY} rst_state_type;
  typedef enum logic [1:0] {WD_OFF, WD_LONG, WD_RUN} wd_state_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } wdc_cmd_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] code;
  } mode_cmd_type;

  typedef struct packed {
    logic       valid;
    logic       reset_delay_sel;
    logic       soft_reset_pin_opt;
    logic       fail_safe_sel;
    logic [1:0] thr;
  } cfg_cmd_type;

  typedef struct packed {
    dev_mode_type        mode;
    rst_state_type       rs;
    wd_state_type        wd;
    logic [RCNT_W-1:0]   rcnt;
    logic [WCNT_W-1:0]   wcnt;
    logic                por;
    logic                rdel;
    logic                rst_out_n;
    logic                wdog_type_sel;
    logic [2:0]          wdog_period_sel;
    logic                reset_delay_sel;
    logic                soft_reset_pin_opt;
    logic                fail_safe_sel;
    logic [1:0]          thr;
    logic [1:0]          wdog_fail_flags;
    logic                spi_fail;
  } sup_state_type;

endpackage

// File: logic/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic [1:0] stage_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= 2'h0;
    end else begin
      stage_r <= {stage_r[0], d};
    end
  end

  assign q = stage_r[1];
endmodule

// File: logic/tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  typedef struct packed {
    logic [supervisor_pkg::TDIV_W-1:0] cnt;
    logic                              tick;
  } tdiv_state_type;

  tdiv_state_type s_r;
  tdiv_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == supervisor_pkg::TDIV_W'(TICK_CYCLES - 1)) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// File: logic/reset_and_watchdog_supervisor.sv
`timescale 1ns/1ps
module reset_and_watchdog_supervisor #(
  parameter int unsigned LW_TICKS    = supervisor_pkg::LW_TICKS,
  parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        vcc1_uv,
  input  wire supervisor_pkg::wdc_cmd_type  wdc_cmd,
  input  wire supervisor_pkg::mode_cmd_type mode_cmd,
  input  wire supervisor_pkg::cfg_cmd_type  cfg_cmd,
  input  wire logic                        spi_fail_clr,
  input  wire logic                        sw_dev_mode,
  input  wire logic                        wdog_stop_off,
  output logic                             reset_out_n,
  output supervisor_pkg::dev_mode_type     dev_mode,
  output logic                             wdog_type_sel,
  output logic [2:0]                       wdog_period_sel,
  output logic                             reset_delay_sel,
  output logic                             soft_reset_pin_opt,
  output logic                             fail_safe_sel,
  output logic [1:0]                       reset_thr_sel,
  output logic [1:0]                       wdog_fail_flags,
  output logic                             spi_fail_flag,
  output logic                             wdog_active
);

  ////////////////////////////////////////////////////////////////////////////

  logic tick;
  logic uv;

  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  sync_two_flop u_uv_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (vcc1_uv),
    .q     (uv)
  );

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [supervisor_pkg::WCNT_W-1:0] scaled_ticks(
    input logic [2:0]  sel,
    input int unsigned pct
  );
    return supervisor_pkg::WCNT_W'(supervisor_pkg::PERIOD_MS[sel] *
                                   supervisor_pkg::MS_TICKS * pct / 100);
  endfunction

  supervisor_pkg::sup_state_type s_r;
  supervisor_pkg::sup_state_type s_nxt;

  logic                              wdc_ok;
  logic                              soft_evt;
  logic                              soft_pin;
  logic                              fail;
  logic                              fail_evt;
  logic                              trig;
  logic                              release_evt;
  logic [supervisor_pkg::WCNT_W-1:0] closed_t;
  logic [supervisor_pkg::WCNT_W-1:0] limit_t;
  logic [supervisor_pkg::RCNT_W-1:0] delay_t;

  assign closed_t = scaled_ticks(s_r.wdog_period_sel, supervisor_pkg::CLOSED_PCT);
  assign limit_t  = s_r.wdog_type_sel ?
                    scaled_ticks(s_r.wdog_period_sel, supervisor_pkg::OPEN_END_PCT) :
                    scaled_ticks(s_r.wdog_period_sel, 100);
  assign delay_t  = (s_r.por || !s_r.rdel) ?
                    supervisor_pkg::RCNT_W'(supervisor_pkg::RD1_TICKS) :
                    supervisor_pkg::RCNT_W'(supervisor_pkg::RD2_TICKS);

  assign wdc_ok   = wdc_cmd.valid && !(^wdc_cmd.data);
  assign soft_evt = mode_cmd.valid && (mode_cmd.code == supervisor_pkg::MODE_CMD_SOFT) &&
                    (s_r.mode == supervisor_pkg::DM_NORMAL ||
                     s_r.mode == supervisor_pkg::DM_STOP);
  assign soft_pin = soft_evt && !s_r.soft_reset_pin_opt;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt       = s_r;
    fail        = 1'b0;
    fail_evt    = 1'b0;
    trig        = 1'b0;
    release_evt = 1'b0;

    if (cfg_cmd.valid) begin
      s_nxt.reset_delay_sel    = cfg_cmd.reset_delay_sel;
      s_nxt.soft_reset_pin_opt = cfg_cmd.soft_reset_pin_opt;
      s_nxt.fail_safe_sel      = cfg_cmd.fail_safe_sel;
      s_nxt.thr                = cfg_cmd.thr;
    end

    // Serial failure flag, set wins over clear
    if (spi_fail_clr) begin
      s_nxt.spi_fail = 1'b0;
    end
    if (wdc_cmd.valid && !wdc_ok) begin
      s_nxt.spi_fail = 1'b1;
    end

    // Watchdog timer
    if (tick && s_r.wd != supervisor_pkg::WD_OFF) begin
      s_nxt.wcnt = s_r.wcnt + 1'b1;
    end
    case (s_r.wd)
      supervisor_pkg::WD_LONG: begin
        if (wdc_ok) begin
          trig = 1'b1;
        end else if (tick && s_r.wcnt >= supervisor_pkg::WCNT_W'(LW_TICKS - 1)) begin
          fail = 1'b1;
        end
      end
      supervisor_pkg::WD_RUN: begin
        if (wdc_ok) begin
          if (s_r.wdog_type_sel && s_r.wcnt < closed_t) begin
            fail = 1'b1;
          end else begin
            trig = 1'b1;
          end
        end else if (tick && s_r.wcnt >= limit_t - 1'b1) begin
          fail = 1'b1;
        end
      end
      supervisor_pkg::WD_OFF: begin
        if (wdc_ok && s_r.mode == supervisor_pkg::DM_STOP) begin
          s_nxt.wd   = supervisor_pkg::WD_LONG;
          s_nxt.wcnt = '0;
        end
      end
      default: begin
        s_nxt.wd = supervisor_pkg::WD_OFF;
      end
    endcase

    if (trig) begin
      s_nxt.wd              = supervisor_pkg::WD_RUN;
      s_nxt.wcnt            = '0;
      s_nxt.wdog_fail_flags = 2'h0;
      if (s_r.mode == supervisor_pkg::DM_NORMAL) begin
        s_nxt.wdog_type_sel   = wdc_cmd.data[supervisor_pkg::WDC_TYPE_BIT];
        s_nxt.wdog_period_sel = wdc_cmd.data[supervisor_pkg::WDC_PERIOD_LSB +: 3];
      end
    end

    if (fail) begin
      if (sw_dev_mode) begin
        s_nxt.wd   = supervisor_pkg::WD_LONG;
        s_nxt.wcnt = '0;
      end else begin
        fail_evt   = 1'b1;
        s_nxt.wd   = supervisor_pkg::WD_OFF;
        s_nxt.mode = s_r.fail_safe_sel ? supervisor_pkg::DM_FAILSAFE :
                                         supervisor_pkg::DM_RESTART;
        if (s_r.wdog_fail_flags != supervisor_pkg::FLAGS_MAX) begin
          s_nxt.wdog_fail_flags = s_r.wdog_fail_flags + 1'b1;
        end
      end
    end

    // Mode commands
    if (mode_cmd.valid && !fail_evt && !soft_evt &&
        s_r.mode != supervisor_pkg::DM_RESTART &&
        s_r.mode != supervisor_pkg::DM_FAILSAFE) begin
      case (mode_cmd.code)
        supervisor_pkg::MODE_CMD_NORMAL: begin
          s_nxt.mode = supervisor_pkg::DM_NORMAL;
          if (s_r.mode == supervisor_pkg::DM_SLEEP ||
              (s_r.mode == supervisor_pkg::DM_STOP && s_r.wd == supervisor_pkg::WD_OFF)) begin
            s_nxt.wd   = supervisor_pkg::WD_LONG;
            s_nxt.wcnt = '0;
          end
        end
        supervisor_pkg::MODE_CMD_SLEEP: begin
          s_nxt.mode            = supervisor_pkg::DM_SLEEP;
          s_nxt.wd              = supervisor_pkg::WD_OFF;
          s_nxt.wdog_fail_flags = 2'h0;
        end
        supervisor_pkg::MODE_CMD_STOP: begin
          s_nxt.mode = supervisor_pkg::DM_STOP;
        end
        default: begin
          s_nxt.mode = s_r.mode;
        end
      endcase
    end

    // Watchdog disabled for Stop
    if (s_r.mode == supervisor_pkg::DM_STOP && wdog_stop_off &&
        s_r.wd != supervisor_pkg::WD_OFF && !wdc_ok) begin
      s_nxt.wd              = supervisor_pkg::WD_OFF;
      s_nxt.wdog_fail_flags = 2'h0;
    end

    // Soft reset restores defaults
    if (soft_evt) begin
      s_nxt.mode               = supervisor_pkg::DM_INIT;
      s_nxt.wdog_type_sel      = supervisor_pkg::TYPE_RST;
      s_nxt.wdog_period_sel    = supervisor_pkg::PERIOD_RST;
      s_nxt.reset_delay_sel    = supervisor_pkg::DSEL_RST;
      s_nxt.soft_reset_pin_opt = supervisor_pkg::PINOPT_RST;
      s_nxt.fail_safe_sel      = supervisor_pkg::FSSEL_RST;
      s_nxt.thr                = supervisor_pkg::THR_RST;
      s_nxt.wdog_fail_flags    = 2'h0;
      s_nxt.spi_fail           = 1'b0;
      s_nxt.wcnt               = '0;
      s_nxt.wd                 = soft_pin ? supervisor_pkg::WD_OFF :
                                            supervisor_pkg::WD_LONG;
    end

    // Reset output sequencer
    case (s_r.rs)
      supervisor_pkg::RS_HIGH: begin
        if (uv) begin
          s_nxt.rs   = supervisor_pkg::RS_FILT;
          s_nxt.rcnt = '0;
        end
      end
      supervisor_pkg::RS_FILT: begin
        if (!uv) begin
          s_nxt.rs = supervisor_pkg::RS_HIGH;
        end else if (tick) begin
          s_nxt.rcnt = s_r.rcnt + 1'b1;
          if (s_r.rcnt >= supervisor_pkg::RCNT_W'(supervisor_pkg::RF_TICKS - 1)) begin
            s_nxt.rs   = supervisor_pkg::RS_LOW;
            s_nxt.rdel = s_r.reset_delay_sel;
          end
        end
      end
      supervisor_pkg::RS_LOW: begin
        if (!uv) begin
          s_nxt.rs   = supervisor_pkg::RS_DELAY;
          s_nxt.rcnt = '0;
        end
      end
      supervisor_pkg::RS_DELAY: begin
        if (uv) begin
          s_nxt.rs = supervisor_pkg::RS_LOW;
        end else if (tick) begin
          s_nxt.rcnt = s_r.rcnt + 1'b1;
          if (s_r.rcnt >= delay_t - 1'b1) begin
            s_nxt.rs    = supervisor_pkg::RS_HIGH;
            s_nxt.por   = 1'b0;
            release_evt = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.rs = supervisor_pkg::RS_LOW;
      end
    endcase

    if (fail_evt || soft_pin) begin
      s_nxt.rs    = supervisor_pkg::RS_LOW;
      s_nxt.rdel  = s_r.reset_delay_sel;
      release_evt = 1'b0;
    end

    if (release_evt) begin
      if (s_r.mode == supervisor_pkg::DM_INIT) begin
        s_nxt.wd   = supervisor_pkg::WD_LONG;
        s_nxt.wcnt = '0;
      end else if (s_r.mode == supervisor_pkg::DM_RESTART ||
                   s_r.mode == supervisor_pkg::DM_FAILSAFE) begin
        s_nxt.mode = supervisor_pkg::DM_NORMAL;
        s_nxt.wd   = supervisor_pkg::WD_LONG;
        s_nxt.wcnt = '0;
      end
    end

    s_nxt.rst_out_n = (s_nxt.rs == supervisor_pkg::RS_HIGH ||
                       s_nxt.rs == supervisor_pkg::RS_FILT);
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r                    <= '0;
      s_r.mode               <= supervisor_pkg::DM_INIT;
      s_r.rs                 <= supervisor_pkg::RS_LOW;
      s_r.wd                 <= supervisor_pkg::WD_OFF;
      s_r.por                <= 1'b1;
      s_r.rst_out_n          <= 1'b0;
      s_r.wdog_type_sel      <= supervisor_pkg::TYPE_RST;
      s_r.wdog_period_sel    <= supervisor_pkg::PERIOD_RST;
      s_r.reset_delay_sel    <= supervisor_pkg::DSEL_RST;
      s_r.soft_reset_pin_opt <= supervisor_pkg::PINOPT_RST;
      s_r.fail_safe_sel      <= supervisor_pkg::FSSEL_RST;
      s_r.thr                <= supervisor_pkg::THR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign reset_out_n        = s_r.rst_out_n;
  assign dev_mode           = s_r.mode;
  assign wdog_type_sel      = s_r.wdog_type_sel;
  assign wdog_period_sel    = s_r.wdog_period_sel;
  assign reset_delay_sel    = s_r.reset_delay_sel;
  assign soft_reset_pin_opt = s_r.soft_reset_pin_opt;
  assign fail_safe_sel      = s_r.fail_safe_sel;
  assign reset_thr_sel      = s_r.thr;
  assign wdog_fail_flags    = s_r.wdog_fail_flags;
  assign spi_fail_flag      = s_r.spi_fail;
  assign wdog_active        = (s_r.wd != supervisor_pkg::WD_OFF);

endmodule

// File: verification/supervisor_checker.sv
`timescale 1ns/1ps
module supervisor_checker #(
  parameter int unsigned LW_TICKS    = supervisor_pkg::LW_TICKS,
  parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         vcc1_uv,
  input wire supervisor_pkg::wdc_cmd_type  wdc_cmd,
  input wire supervisor_pkg::mode_cmd_type mode_cmd,
  input wire supervisor_pkg::cfg_cmd_type  cfg_cmd,
  input wire logic                         reset_out_n,
  input wire supervisor_pkg::dev_mode_type dev_mode,
  input wire logic                         wdog_type_sel,
  input wire logic [2:0]                   wdog_period_sel,
  input wire logic                         reset_delay_sel,
  input wire logic                         soft_reset_pin_opt,
  input wire logic                         fail_safe_sel,
  input wire logic [1:0]                   wdog_fail_flags,
  input wire logic                         spi_fail_flag,
  input wire logic                         wdog_active
);
  localparam int unsigned MIN_LOW = (supervisor_pkg::RD2_TICKS - 1) * TICK_CYCLES;
  logic [19:0] low_cnt_r;
  logic        soft_ok;
  logic        good_wr;
  assign soft_ok = mode_cmd.valid && mode_cmd.code == supervisor_pkg::MODE_CMD_SOFT &&
                   (dev_mode == supervisor_pkg::DM_NORMAL || dev_mode == supervisor_pkg::DM_STOP);
  assign good_wr = wdc_cmd.valid && !(^wdc_cmd.data) && !mode_cmd.valid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= '0;
    end else if (reset_out_n) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != '1) begin
      low_cnt_r <= low_cnt_r + 20'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  chk_parity_refuse: assert property (
    wdc_cmd.valid && (^wdc_cmd.data) && !mode_cmd.valid |=> spi_fail_flag &&
      $stable(wdog_type_sel) && $stable(wdog_period_sel)) else $error("parity refusal");
  chk_good_trig_clr: assert property (
    good_wr && wdog_active && !wdog_type_sel && !wdc_cmd.data[3] &&
      dev_mode == supervisor_pkg::DM_NORMAL |=> wdog_fail_flags == 2'h0)
    else $error("flags not cleared");
  chk_soft_init: assert property (
    soft_ok |=> dev_mode == supervisor_pkg::DM_INIT && wdog_type_sel == supervisor_pkg::TYPE_RST &&
      wdog_period_sel == supervisor_pkg::PERIOD_RST) else $error("soft reset state");
  chk_soft_ignore: assert property (
    mode_cmd.valid && mode_cmd.code == supervisor_pkg::MODE_CMD_SOFT && !cfg_cmd.valid &&
      dev_mode == supervisor_pkg::DM_INIT |=> $stable(reset_delay_sel))
    else $error("soft not ignored");
  chk_soft_pin: assert property (
    soft_ok |=> reset_out_n == ($past(soft_reset_pin_opt) && $past(reset_out_n)))
    else $error("pin option");
  chk_stop_keep: assert property (
    good_wr && dev_mode == supervisor_pkg::DM_STOP |=> $stable(wdog_type_sel) &&
      $stable(wdog_period_sel)) else $error("config changed in stop");
  chk_normal_take: assert property (
    good_wr && dev_mode == supervisor_pkg::DM_NORMAL |=>
      wdog_period_sel == $past(wdc_cmd.data[2:0]) && wdog_type_sel == $past(wdc_cmd.data[3]))
    else $error("config not taken");
  chk_uv_filter: assert property (
    $rose(vcc1_uv) && reset_out_n |-> ##1 reset_out_n ##1
      (vcc1_uv throughout ##[1:1000] !reset_out_n)) else $error("uv reset timing");
  chk_release_delay: assert property (
    $rose(reset_out_n) |-> low_cnt_r >= MIN_LOW) else $error("release delay short");
  chk_fail_mode: assert property (
    $fell(wdog_active) && $fell(reset_out_n) && !$past(mode_cmd.valid) |->
      dev_mode == (fail_safe_sel ? supervisor_pkg::DM_FAILSAFE : supervisor_pkg::DM_RESTART) &&
      wdog_fail_flags != 2'h0) else $error("failure state");
  chk_resume_normal: assert property (
    $rose(reset_out_n) && ($past(dev_mode) == supervisor_pkg::DM_RESTART ||
      $past(dev_mode) == supervisor_pkg::DM_FAILSAFE) |->
      dev_mode == supervisor_pkg::DM_NORMAL && wdog_active) else $error("no resume");
  cov_soft: cover property (soft_ok);
  cov_fail: cover property ($fell(wdog_active) && !reset_out_n);
  cov_release: cover property ($rose(reset_out_n));
endmodule

bind reset_and_watchdog_supervisor supervisor_checker #(.LW_TICKS(LW_TICKS),
  .TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// File: verification/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   req,
  input  wire logic [14:0]            req_data,
  input  wire logic                   req_bad,
  output supervisor_pkg::wdc_cmd_type wdc_cmd
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdc_cmd <= '0;
    end else if (req) begin
      wdc_cmd.valid <= 1'b1;
      wdc_cmd.data  <= {(^req_data) ^ req_bad, req_data};
    end else begin
      wdc_cmd.valid <= 1'b0;
      wdc_cmd.data  <= ~wdc_cmd.data;
    end
  end
endmodule

// File: verification/reset_and_watchdog_supervisor_tb_top.sv
`timescale 1ns/1ps
module reset_and_watchdog_supervisor_tb_top;
  typedef struct packed {
    logic rst; supervisor_pkg::dev_mode_type mode; logic typ; logic [2:0] per;
    logic dsel; logic popt; logic fs; logic [1:0] thr; logic [1:0] flags; logic spi; logic act;
  } obs_type;
  localparam int unsigned LW = 20;
  localparam int unsigned TC = 50;
  logic clk, rst_n, vcc1_uv, spi_fail_clr, sw_dev_mode, req, req_bad;
  logic [14:0] req_data;
  supervisor_pkg::wdc_cmd_type  wdc_cmd;
  supervisor_pkg::mode_cmd_type mode_cmd;
  supervisor_pkg::cfg_cmd_type  cfg_cmd;
  supervisor_pkg::dev_mode_type dev_mode;
  logic reset_out_n, wdog_type_sel, reset_delay_sel, soft_reset_pin_opt, fail_safe_sel;
  logic spi_fail_flag, wdog_active;
  logic [2:0] wdog_period_sel;
  logic [1:0] reset_thr_sel, wdog_fail_flags;
  obs_type obs, e;
  obs_type exp_q[$], mask_q[$];
  string   name_q[$];
  event    chk_ev;
  int      fail_count, tests_run, cyc, n;
  assign obs = {reset_out_n, dev_mode, wdog_type_sel, wdog_period_sel, reset_delay_sel,
                soft_reset_pin_opt, fail_safe_sel, reset_thr_sel, wdog_fail_flags,
                spi_fail_flag, wdog_active};
  host_model u_host (.*);
  reset_and_watchdog_supervisor #(.LW_TICKS(LW), .TICK_CYCLES(TC)) DUT (
    .wdog_stop_off(1'b0), .*);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90_000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    forever begin
      @(chk_ev);
      while (exp_q.size() > 0) begin
        obs_type x, m;
        string   s;
        x = exp_q.pop_front();
        m = mask_q.pop_front();
        s = name_q.pop_front();
        tests_run++;
        if (((obs ^ x) & m) !== '0) begin
          $display("CHECK FAILED %s expected %h seen %h", s, x & m, obs & m);
          fail_count++;
        end
      end
    end
  end
  task automatic note(input string s, input obs_type m = '1);
    exp_q.push_back(e);
    mask_q.push_back(m);
    name_q.push_back(s);
    -> chk_ev;
  endtask
  task automatic chk_true(input string s, input logic c);
    tests_run++;
    if (c !== 1'b1) begin
      $display("CHECK FAILED %s expected 1 seen %b", s, c);
      fail_count++;
    end
  endtask
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic host_write(input logic [14:0] d, input logic bad);
    req = 1'b1;
    req_data = d;
    req_bad = bad;
    step();
    req = 1'b0;
    step();
  endtask
  task automatic mode(input logic [1:0] c);
    mode_cmd = '{1'b1, c};
    step();
    mode_cmd.valid = 1'b0;
  endtask
  task automatic cfg(input logic ds, input logic po, input logic fs, input logic [1:0] th);
    step();
    cfg_cmd = '{1'b1, ds, po, fs, th};
    step();
    cfg_cmd.valid = 1'b0;
    e.dsel = ds;
    e.popt = po;
    e.fs = fs;
    e.thr = th;
  endtask
  task automatic wait_rst(input logic lvl, input int maxc);
    n = 0;
    while (reset_out_n !== lvl && n < maxc) begin
      step();
      n++;
    end
    chk_true("reset_out_n wait", n < maxc);
  endtask
  initial begin
    rst_n = 1'b0; vcc1_uv = 1'b0; spi_fail_clr = 1'b0; sw_dev_mode = 1'b0;
    req = 1'b0; req_bad = 1'b0; req_data = '0; mode_cmd = '0; cfg_cmd = '0;
    void'($urandom(77815));
    e = '{1'b0, supervisor_pkg::DM_INIT, 1'b0, 3'h2, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0};
    step(16);
    note("reset defaults");
    rst_n = 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 2'h3);
    note("config write");
    mode(supervisor_pkg::MODE_CMD_SOFT);
    note("soft reset in init");
    wait_rst(1'b1, 51_000);
    chk_true("power-up delay", n >= (supervisor_pkg::RD1_TICKS - 2) * TC);
    e.rst = 1'b1;
    e.act = 1'b1;
    note("power-up release");
    mode(supervisor_pkg::MODE_CMD_NORMAL);
    e.mode = supervisor_pkg::DM_NORMAL;
    note("normal mode");
    for (int p = 0; p < 8; p++) begin
      host_write({11'($urandom()), 1'b0, 3'(p)}, 1'b0);
      e.per = 3'(p);
      note("period select");
    end
    host_write(15'h0035, 1'b1);
    e.spi = 1'b1;
    note("parity refusal");
    step();
    spi_fail_clr = 1'b1;
    step();
    spi_fail_clr = 1'b0;
    e.spi = 1'b0;
    note("serial flag clear");
    e.per = 3'($urandom());
    host_write({11'h000, 1'b1, e.per}, 1'b0);
    e.typ = 1'b1;
    note("window select");
    host_write({11'h000, 1'b1, e.per}, 1'b0);
    e = '{1'b0, supervisor_pkg::DM_RESTART, 1'b1, e.per, 1'b1, 1'b0, 1'b0, 2'h3, 2'h1, 1'b0, 1'b0};
    note("closed window trigger");
    wait_rst(1'b1, 11_000);
    chk_true("release delay two", n >= (supervisor_pkg::RD2_TICKS - 2) * TC);
    e.rst = 1'b1;
    e.mode = supervisor_pkg::DM_NORMAL;
    e.act = 1'b1;
    note("restart resume");
    sw_dev_mode = 1'b1;
    step(LW * TC + 1000);
    note("development mode miss");
    sw_dev_mode = 1'b0;
    cfg(1'b1, 1'b0, 1'b1, 2'h3);
    wait_rst(1'b0, (LW + 2) * TC);
    e.rst = 1'b0;
    e.mode = supervisor_pkg::DM_FAILSAFE;
    e.flags = 2'h2;
    e.act = 1'b0;
    note("long window miss");
    wait_rst(1'b1, 11_000);
    e.rst = 1'b1;
    e.mode = supervisor_pkg::DM_NORMAL;
    e.act = 1'b1;
    note("fail-safe resume");
    host_write({11'($urandom()), 1'b0, 3'h3}, 1'b0);
    e.typ = 1'b0;
    e.per = 3'h3;
    e.flags = 2'h0;
    note("good trigger");
    mode(supervisor_pkg::MODE_CMD_STOP);
    e.mode = supervisor_pkg::DM_STOP;
    host_write({11'h000, 1'b1, 3'h5}, 1'b0);
    note("stop keeps config");
    cfg(1'b1, 1'b1, 1'b1, 2'h3);
    mode(supervisor_pkg::MODE_CMD_SOFT);
    e = '{1'b1, supervisor_pkg::DM_INIT, 1'b0, 3'h2, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1};
    note("soft reset pin kept");
    vcc1_uv = 1'b1;
    wait_rst(1'b0, 1000);
    chk_true("filter time", n >= 2);
    e.rst = 1'b0;
    note("undervoltage reset", '{rst: 1'b1, mode: supervisor_pkg::DM_INIT, default: '0});
    step(2);
    end_sim();
  end
endmodule
